// File: gtc_timer_pair.sv
// Package and top level of the gated timer/counter pair with APB access.
// Assumes an APB master on CLK; pins arrive asynchronously.
// Behaviour
// - Each counter leaves reset in mode zero, the thirteen-bit mode.
// - Two mode-select bits per counter pick one of four modes.
// - A select bit picks internal clock ticks or count-pin pulses.
// - Each counter's overflow flag sits in the control register, set on overflow.
// - External request: low-level triggered if trigger bit clear, falling edge if set.
// - Level mode re-raises the request while pin stays low.
// - Gate bit set and gate pin low: counter holds even when running.
// - Gate bit set, run set: counts while gate pin is high.
// - Clearing run stops the counter at once, regardless of gate.
// - Mode one is a sixteen-bit up-counter, flags overflow, no reload.
// - Counter zero overflow vectors to code address 0x0B.
// - A request is taken only with no higher unmasked pending, nor equal or higher in service.
// - Both counters' bits share one control and one mode register.
// - Counter one behaves as counter zero with its own bits and pins.
package gtc_pkg;
	localparam int NUM_TIMERS = 2;
	localparam int NUM_SRC = 4;
	localparam int MODE0_LOW_BITS = 5;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [3:0] MASK_RESET = 4'h0;
	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_COUNT0 = 8'h08;
	localparam logic [7:0] ADDR_COUNT1 = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_TAKE = 8'h18;
	localparam logic [7:0] ADDR_DONE = 8'h1C;
	// Control register: per timer the fields step by CTRL_STRIDE
	localparam int CTRL_STRIDE = 2;
	localparam int CTRL_IT_POS = 0;
	localparam int CTRL_IE_POS = 1;
	localparam int CTRL_TR_POS = 4;
	localparam int CTRL_TF_POS = 5;
	// Mode register: one nibble per timer
	localparam int MODE_STRIDE = 4;
	localparam int MODE_M_POS = 0;
	localparam int MODE_CT_POS = 2;
	localparam int MODE_GATE_POS = 3;
	// Interrupt sources in priority order, highest first
	localparam int SRC_STRIDE = 2;
	localparam int SRC_EXT = 0;
	localparam int SRC_OVF = 1;
	localparam logic [7:0] VEC_BASE = 8'h03;
	localparam logic [7:0] VEC_STEP = 8'h08;
	localparam int TAKE_VALID_POS = 31;
	localparam int TAKE_SERV_POS = 8;

	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_8BIT_RELOAD,
		MODE_SPLIT
	} gtc_mode_e;

	typedef struct packed {
		logic gate;
		logic counter_sel;
		gtc_mode_e mode;
	} gtc_cfg_s;

	typedef struct packed {
		logic wr_low;
		logic wr_high;
		logic [7:0] data_low;
		logic [7:0] data_high;
	} gtc_cnt_wr_s;
endpackage

`timescale 1ns/1ps
`default_nettype none
module gtc_timer_pair
	import gtc_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Pins, one bit per timer
	input wire logic [1:0] EXTERNAL_COUNT_PIN,
	input wire logic [1:0] EXTERNAL_GATE_PIN,
	// Interrupt
	output logic IRQ,
	output logic [7:0] TAKEN_VECTOR
);
	logic [7:0] timer_control_register;
	logic [7:0] timer_mode_register;
	logic [3:0] irq_mask;
	logic [3:0] in_service;
	logic [3:0] pending;
	logic [15:0] count_word [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] overflow;
	logic [NUM_TIMERS-1:0] ext_event;
	logic [NUM_TIMERS-1:0] gate_sync;
	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic take_wr;
	logic done_wr;
	logic take_ok;
	logic [1:0] take_src;
	logic take_any;
	logic [3:0] take_clear;
	logic [3:0] done_clear;
	logic [31:0] next_rdata;

	// Access phase takes two cycles; PREADY comes from a flop
	assign access = PSEL & PENABLE;
	assign wr_en = access & PREADY & PWRITE;
	assign rd_en = access & ~PREADY & ~PWRITE;
	assign take_wr = wr_en & (PADDR == ADDR_TAKE);
	assign done_wr = wr_en & (PADDR == ADDR_DONE);

	always_comb
	begin
		mapped = 1'b1;
		case (PADDR)
		ADDR_CTRL, ADDR_MODE, ADDR_COUNT0, ADDR_COUNT1,
		ADDR_STATUS, ADDR_MASK, ADDR_TAKE, ADDR_DONE:
			mapped = 1'b1;
		default:
			mapped = 1'b0;
		endcase
	end

	// Pending flags in priority order
	genvar ch;
	generate
		for (ch = 0; ch < NUM_TIMERS; ch++)
		begin : g_src
			assign pending[ch*SRC_STRIDE+SRC_EXT] =
				timer_control_register[ch*CTRL_STRIDE+CTRL_IE_POS];
			assign pending[ch*SRC_STRIDE+SRC_OVF] =
				timer_control_register[ch*CTRL_STRIDE+CTRL_TF_POS];
		end
	endgenerate

	// Highest unmasked pending source; blocked by equal or higher service
	always_comb
	begin
		take_any = 1'b0;
		take_src = 2'd0;
		for (int k = NUM_SRC - 1; k >= 0; k--)
		begin
			if (pending[k] & irq_mask[k])
			begin
				take_any = 1'b1;
				take_src = k[1:0];
			end
		end
		take_ok = take_any;
		for (int k = 0; k < NUM_SRC; k++)
		begin
			if (in_service[k] && (k[1:0] <= take_src))
				take_ok = 1'b0;
		end
	end

	always_comb
	begin
		take_clear = 4'h0;
		done_clear = 4'h0;
		if (take_wr & take_ok)
			take_clear[take_src] = 1'b1;
		for (int k = NUM_SRC - 1; k >= 0; k--)
		begin
			if (in_service[k])
			begin
				done_clear = 4'h0;
				done_clear[k] = done_wr;
			end
		end
	end

	// Per-timer pins, flags and counter
	generate
		for (ch = 0; ch < NUM_TIMERS; ch++)
		begin : g_timer
			localparam int TF = ch * CTRL_STRIDE + CTRL_TF_POS;
			localparam int TR = ch * CTRL_STRIDE + CTRL_TR_POS;
			localparam int IE = ch * CTRL_STRIDE + CTRL_IE_POS;
			localparam int IT = ch * CTRL_STRIDE + CTRL_IT_POS;
			localparam int MB = ch * MODE_STRIDE;
			localparam int SE = ch * SRC_STRIDE + SRC_EXT;
			localparam int SO = ch * SRC_STRIDE + SRC_OVF;
			localparam logic [7:0] ADDR_CNT = ch == 0 ? ADDR_COUNT0
				: ADDR_COUNT1;
			logic gate_meta;
			logic gate_prev;
			logic count_meta;
			logic count_sync;
			logic count_prev;
			logic count_fall;
			gtc_cfg_s cfg;
			gtc_cnt_wr_s cnt_wr;
			logic ovf_clr;
			logic ext_clr;
			logic [7:0] cnt_low;
			logic [7:0] cnt_high;

			// Two flops before any logic sees a pin
			always_ff @(posedge CLK or negedge RESET_N)
			begin
				if (!RESET_N)
				begin
					gate_meta <= 1'b1;
					gate_sync[ch] <= 1'b1;
					gate_prev <= 1'b1;
					count_meta <= 1'b0;
					count_sync <= 1'b0;
					count_prev <= 1'b0;
				end
				else if (CE)
				begin
					gate_meta <= EXTERNAL_GATE_PIN[ch];
					gate_sync[ch] <= gate_meta;
					gate_prev <= gate_sync[ch];
					count_meta <= EXTERNAL_COUNT_PIN[ch];
					count_sync <= count_meta;
					count_prev <= count_sync;
				end
			end

			assign count_fall = count_prev & ~count_sync;
			// Level mode keeps asserting while the pin is low
			assign ext_event[ch] = timer_control_register[IT]
				? (gate_prev & ~gate_sync[ch])
				: ~gate_sync[ch];

			assign cfg.gate = timer_mode_register[MB+MODE_GATE_POS];
			assign cfg.counter_sel = timer_mode_register[MB+MODE_CT_POS];
			assign cfg.mode = gtc_mode_e'(
				timer_mode_register[MB+MODE_M_POS +: 2]);
			assign cnt_wr.wr_low = wr_en & (PADDR == ADDR_CNT) & PSTRB[0];
			assign cnt_wr.wr_high = wr_en & (PADDR == ADDR_CNT) & PSTRB[1];
			assign cnt_wr.data_low = PWDATA[7:0];
			assign cnt_wr.data_high = PWDATA[15:8];
			assign count_word[ch] = {cnt_high, cnt_low};

			// Clears: control write of zero, status write of one, take
			assign ovf_clr = (wr_en & (PADDR == ADDR_CTRL) & PSTRB[0]
				& ~PWDATA[TF])
				| (wr_en & (PADDR == ADDR_STATUS) & PSTRB[0] & PWDATA[SO])
				| take_clear[SO];
			assign ext_clr = (wr_en & (PADDR == ADDR_CTRL) & PSTRB[0]
				& ~PWDATA[IE])
				| (wr_en & (PADDR == ADDR_STATUS) & PSTRB[0] & PWDATA[SE])
				| take_clear[SE];

			// Flags: hardware set wins over any clear
			always_ff @(posedge CLK or negedge RESET_N)
			begin
				if (!RESET_N)
				begin
					timer_control_register[TF] <= CTRL_RESET[TF];
					timer_control_register[IE] <= CTRL_RESET[IE];
					timer_control_register[TR] <= CTRL_RESET[TR];
					timer_control_register[IT] <= CTRL_RESET[IT];
				end
				else if (CE)
				begin
					if (overflow[ch])
						timer_control_register[TF] <= 1'b1;
					else if (ovf_clr)
						timer_control_register[TF] <= 1'b0;
					if (ext_event[ch])
						timer_control_register[IE] <= 1'b1;
					else if (ext_clr)
						timer_control_register[IE] <= 1'b0;
					// Run and trigger type: software-owned, one writer
					if (wr_en && PADDR == ADDR_CTRL && PSTRB[0])
					begin
						timer_control_register[TR] <= PWDATA[TR];
						timer_control_register[IT] <= PWDATA[IT];
					end
				end
			end

			// Same unit for both timers, own bits and pins
			gtc_timer_unit u_unit (
				.clk(CLK),
				.rst_n(RESET_N),
				.ce(CE),
				.cfg(cfg),
				.run(timer_control_register[TR]),
				.gate_level(gate_sync[ch]),
				.count_fall(count_fall),
				.cnt_wr(cnt_wr),
				.count_low(cnt_low),
				.count_high(cnt_high),
				.overflow(overflow[ch])
			);
		end
	endgenerate

	// Mode register and mask
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			timer_mode_register <= MODE_RESET;
			irq_mask <= MASK_RESET;
		end
		else if (CE && wr_en && PSTRB[0])
		begin
			if (PADDR == ADDR_MODE)
				timer_mode_register <= PWDATA[7:0];
			if (PADDR == ADDR_MASK)
				irq_mask <= PWDATA[3:0];
		end
	end

	// Service tracking and vector of the request just taken
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			in_service <= 4'h0;
			TAKEN_VECTOR <= 8'h00;
		end
		else if (CE)
		begin
			in_service <= (in_service | take_clear) & ~done_clear;
			if (take_wr & take_ok)
				TAKEN_VECTOR <= VEC_BASE
					+ 8'(VEC_STEP * {6'h00, take_src});
		end
	end

	// Level interrupt while any unmasked flag stands
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			IRQ <= 1'b0;
		else if (CE)
			IRQ <= |(pending & irq_mask);
	end

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (PADDR)
		ADDR_CTRL: next_rdata[7:0] = timer_control_register;
		ADDR_MODE: next_rdata[7:0] = timer_mode_register;
		ADDR_COUNT0: next_rdata[15:0] = count_word[0];
		ADDR_COUNT1: next_rdata[15:0] = count_word[1];
		ADDR_STATUS: next_rdata[3:0] = pending;
		ADDR_MASK: next_rdata[3:0] = irq_mask;
		ADDR_TAKE:
		begin
			next_rdata[7:0] = TAKEN_VECTOR;
			next_rdata[TAKE_SERV_POS +: 4] = in_service;
			next_rdata[TAKE_VALID_POS] = take_ok;
		end
		default: next_rdata = 32'h0000_0000;
		endcase
	end

	// APB answer: one wait state, error on unmapped address
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end
		else if (CE)
		begin
			PREADY <= access & ~PREADY;
			PSLVERR <= access & ~PREADY & ~mapped;
			if (rd_en)
				PRDATA <= next_rdata;
		end
	end
endmodule
`default_nettype wire

// File: gtc_timer_unit.sv
// One timer/counter: count registers, mode handling and overflow pulse.
// Assumes count_fall and gate_level are already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_unit
	import gtc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Setup from the mode and control registers
	input wire gtc_cfg_s cfg,
	input wire logic run,
	// Pin events
	input wire logic gate_level,
	input wire logic count_fall,
	// Software writes to the count bytes
	input wire gtc_cnt_wr_s cnt_wr,
	// State
	output logic [7:0] count_low,
	output logic [7:0] count_high,
	output logic overflow
);
	logic enable;
	logic tick;
	logic [12:0] next_thirteen;
	logic [15:0] next_sixteen;

	// Gate pin only matters while the gate bit is set
	assign enable = run & (~cfg.gate | gate_level);
	assign tick = enable & (cfg.counter_sel ? count_fall : 1'b1);
	assign next_thirteen = {count_high, count_low[MODE0_LOW_BITS-1:0]}
		+ 13'h0001;
	assign next_sixteen = {count_high, count_low} + 16'h0001;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_low <= CNT_RESET;
			count_high <= CNT_RESET;
			overflow <= 1'b0;
		end
		else if (ce)
		begin
			overflow <= 1'b0;
			if (tick)
			begin
				case (cfg.mode)
				MODE_13BIT:
				begin
					count_high <= next_thirteen[12:MODE0_LOW_BITS];
					count_low[MODE0_LOW_BITS-1:0] <=
						next_thirteen[MODE0_LOW_BITS-1:0];
					overflow <= &{count_high,
						count_low[MODE0_LOW_BITS-1:0]};
				end
				MODE_16BIT:
				begin
					// No reload here; software restores the start value
					{count_high, count_low} <= next_sixteen;
					overflow <= &{count_high, count_low};
				end
				MODE_8BIT_RELOAD:
				begin
					if (&count_low)
					begin
						count_low <= count_high;
						overflow <= 1'b1;
					end
					else
						count_low <= count_low + 8'h01;
				end
				default:
				begin
					// Split mode not modelled: counter holds
					count_low <= count_low;
				end
				endcase
			end
			// Software write wins over a tick in the same cycle
			if (cnt_wr.wr_low)
				count_low <= cnt_wr.data_low;
			if (cnt_wr.wr_high)
				count_high <= cnt_wr.data_high;
		end
	end
endmodule
`default_nettype wire

// File: gtc_pair_checker.sv
// Port checker for the timer pair: APB answer and vector rules.
// Assumes binding to gtc_timer_pair; CLK domain, RESET_N async low.
`timescale 1ns/1ps
`default_nettype none
module gtc_pair_checker
	import gtc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CE,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Interrupt side
	input wire logic IRQ,
	input wire logic [7:0] TAKEN_VECTOR
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_access;
		CE && PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_done;
		PSEL && PENABLE && PREADY;
	endsequence
	chk_ready_answer: assert property (s_access |=> PREADY)
		else $error("PREADY missing after access");
	chk_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("PREADY held too long");
	chk_ready_cause: assert property (!PSEL |=> !PREADY)
		else $error("PREADY without request");
	chk_err_unmapped: assert property ((s_access and (PADDR > ADDR_DONE))
		|=> PSLVERR) else $error("No error on unmapped address");
	chk_err_mapped: assert property ((s_access and (PADDR <= ADDR_DONE
		&& PADDR[1:0] == 2'b00)) |=> !PSLVERR)
		else $error("Error on mapped address");
	chk_err_read_zero: assert property ((s_done and (PSLVERR && !PWRITE))
		|-> PRDATA == 32'h0000_0000) else $error("Unmapped read not zero");
	chk_vector_legal:
		assert property (TAKEN_VECTOR inside {8'h00, 8'h03, 8'h0B, 8'h13,
		8'h1B}) else $error("Vector outside table");
	chk_vector_cause:
		assert property (!$stable(TAKEN_VECTOR) |-> $past(PWRITE)
		&& $past(PREADY) && $past(PADDR) == ADDR_TAKE)
		else $error("Vector moved without take");
endmodule
bind gtc_timer_pair gtc_pair_checker gtc_pair_checker_i (.CLK(CLK),
	.RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .IRQ(IRQ), .TAKEN_VECTOR(TAKEN_VECTOR));
`default_nettype wire

// File: gtc_pin_model.sv
// Model of the count and gate pins beside the timer pair.
// Assumes one caller at a time; changes land just after CLK rises.
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_model
(
	// Clock
	input wire logic clk,
	// Pins toward the timer pair
	output logic [1:0] count_pin,
	output logic [1:0] gate_pin
);
	int t;
	initial
	begin
		count_pin = 2'b11;
		gate_pin = 2'b11;
	end
	// Three clocks per phase so the two-flop sync never drops one
	task pulse(input int tn, input int n);
		t = tn;
		repeat (n)
		begin
			@(posedge clk);
			count_pin[t] <= 1'b0;
			repeat (3) @(posedge clk);
			count_pin[t] <= 1'b1;
			repeat (3) @(posedge clk);
		end
	endtask
	// Bench leaves gate pin 0 low from the edge test on, through service
	task set_gate(input int tn, input logic lv);
		t = tn;
		@(posedge clk);
		gate_pin[t] <= lv;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the timer pair over APB with the pin model.
// Assumes the design answers each access before the watchdog runs out.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import gtc_pkg::*;
;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, taken_vector, r;
	logic [31:0] pwdata, prdata;
	logic [1:0] cnt_pin, gate_pin;
	logic [15:0] v;
	logic [15:0] exp_q[$];
	logic [15:0] msk_q[$];
	int failures, n_checks, seed;
	gtc_timer_pair gtc_timer_pair_i (.CLK(clk), .RESET_N(reset_n),
		.CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .EXTERNAL_COUNT_PIN(cnt_pin),
		.EXTERNAL_GATE_PIN(gate_pin), .IRQ(irq),
		.TAKEN_VECTOR(taken_vector));
	gtc_pin_model gtc_pin_model_i (.clk(clk), .count_pin(cnt_pin),
		.gate_pin(gate_pin));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task cmp(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask
	// Expected value noted first; the monitor compares on PREADY
	task rd(input logic [7:0] a, input logic [15:0] e, m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		apb(1'b0, a, 16'h0000);
	endtask
	// Two falling edges let the one-cycle IRQ latency land
	task chk_irq(input logic e);
		repeat (2) @(negedge clk);
		cmp("IRQ", {31'b0, irq}, {31'b0, e});
	endtask
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			cmp("PRDATA", prdata & {16'h0000, msk_q.pop_front()},
				{16'h0000, exp_q.pop_front()});
	end
	initial
	begin
		#2000000;
		failures++;
		stop_test;
	end
	initial
	begin
		seed = 32'h5a4b;
		failures = 0;
		n_checks = 0;
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd(ADDR_CTRL, 16'h0000, 16'hFFFF);
		rd(ADDR_MODE, 16'h0000, 16'hFFFF);
		rd(8'h20, 16'h0000, 16'hFFFF);
		for (int i = 0; i < 4; i++)
		begin
			r = 8'($random(seed));
			v = {8'h00, r[7:6], 2'(i), r[3:2], 2'(i)};
			wr(ADDR_MODE, v);
			rd(ADDR_MODE, v, 16'hFFFF);
		end
		// Sixteen-bit run through overflow, then mask and clear
		wr(ADDR_MODE, 16'h0001);
		wr(ADDR_MASK, 16'h0002);
		wr(ADDR_COUNT0, 16'hFFF0);
		wr(ADDR_CTRL, 16'h0010);
		repeat (30) @(posedge clk);
		chk_irq(1'b1);
		rd(ADDR_STATUS, 16'h0002, 16'hFFFF);
		rd(ADDR_COUNT0, 16'h0000, 16'hFF00);
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_COUNT0, 16'h1234);
		repeat (20) @(posedge clk);
		rd(ADDR_COUNT0, 16'h1234, 16'hFFFF);
		wr(ADDR_MASK, 16'h0000);
		chk_irq(1'b0);
		wr(ADDR_STATUS, 16'h000F);
		wr(ADDR_MASK, 16'h0002);
		// Gated timer with the gate pin held low first
		gtc_pin_model_i.set_gate(0, 1'b0);
		wr(ADDR_MODE, 16'h0009);
		wr(ADDR_COUNT0, 16'h00F0);
		wr(ADDR_CTRL, 16'h0010);
		repeat (20) @(posedge clk);
		rd(ADDR_COUNT0, 16'h00F0, 16'hFFFF);
		wr(ADDR_STATUS, 16'h0001);
		rd(ADDR_STATUS, 16'h0001, 16'h0001);
		gtc_pin_model_i.set_gate(0, 1'b1);
		repeat (30) @(posedge clk);
		gtc_pin_model_i.set_gate(0, 1'b0);
		repeat (5) @(posedge clk);
		rd(ADDR_COUNT0, 16'h0100, 16'hFF00);
		// Edge mode: a held low level no longer requests
		wr(ADDR_CTRL, 16'h0001);
		wr(ADDR_STATUS, 16'h0001);
		rd(ADDR_STATUS, 16'h0000, 16'h0001);
		gtc_pin_model_i.set_gate(0, 1'b1);
		repeat (3) @(posedge clk);
		gtc_pin_model_i.set_gate(0, 1'b0);
		repeat (4) @(posedge clk);
		rd(ADDR_STATUS, 16'h0001, 16'h0001);
		// Eight-bit reload keeps the low byte within F0..FF
		wr(ADDR_MODE, 16'h0002);
		wr(ADDR_COUNT0, 16'hF0FE);
		wr(ADDR_CTRL, 16'h0013);
		repeat (40) @(posedge clk);
		rd(ADDR_COUNT0, 16'hF0F0, 16'hFFF0);
		rd(ADDR_STATUS, 16'h0003, 16'h0003);
		wr(ADDR_CTRL, 16'h0023);
		// Priority: external before overflow, refused while in service
		wr(ADDR_MASK, 16'h0003);
		wr(ADDR_TAKE, 16'h0000);
		rd(ADDR_TAKE, 16'h0003, 16'h00FF);
		wr(ADDR_TAKE, 16'h0000);
		rd(ADDR_TAKE, 16'h0003, 16'h00FF);
		wr(ADDR_DONE, 16'h0000);
		wr(ADDR_TAKE, 16'h0000);
		rd(ADDR_TAKE, 16'h000B, 16'h00FF);
		wr(ADDR_DONE, 16'h0000);
		// Both counters on count pins with different totals
		wr(ADDR_MODE, 16'h0055);
		wr(ADDR_COUNT0, 16'h0000);
		wr(ADDR_COUNT1, 16'h0000);
		wr(ADDR_CTRL, 16'h0050);
		gtc_pin_model_i.pulse(0, 5);
		gtc_pin_model_i.pulse(1, 3);
		repeat (5) @(posedge clk);
		rd(ADDR_COUNT0, 16'h0005, 16'hFFFF);
		rd(ADDR_COUNT1, 16'h0003, 16'hFFFF);
		stop_test;
	end
endmodule
`default_nettype wire
